// File: hdl/pfcr_consts.svh
// Constants for the trim, light-load filter and current balance registers.
// Assumes a byte-wide internal register port from the management bus engine.
//
// What this block does
// R1 - Trim bit 7 picks the sign: one negative, zero positive.
// R2 - The low seven trim bits are the magnitude, 0.0625/128 a step.
// R3 - At low line and light load the filter takes the low-line pair.
// R4 - At high line and light load the filter takes the high-line pair.
// R5 - Light-load pairs apply only while enable bit 5 at 0xFE4F is one.
// R6 - The power reading is a read-only 16-bit average of 16 line cycles.
// R7 - Balance bit 7 at one removes the correction from the PWM outputs.
// R8 - Balance bit 6 at zero suspends balancing while the fast loop is on.
// R9 - Software is advised to leave balance bit 6 at zero.
// R10 - Balance bit 3 at one stops low power balancing at the limit.
// R11 - Software is advised to set balance bit 3 to one.
// R12 - Reserved balance bits read as zero and ignore writes.
`ifndef PFCR_CONSTS_SVH
`define PFCR_CONSTS_SVH

// Register addresses
`define PFCR_ADDR_TRIM      16'hFE8F
`define PFCR_ADDR_LL_GAIN   16'hFE90
`define PFCR_ADDR_LL_ZERO   16'hFE91
`define PFCR_ADDR_HL_GAIN   16'hFE92
`define PFCR_ADDR_HL_ZERO   16'hFE93
`define PFCR_ADDR_PWR       16'hFE94
`define PFCR_ADDR_BAL       16'hFE95

// Field positions
`define PFCR_TRIM_SIGN_BIT  7
`define PFCR_TRIM_MAG_MSB   6
`define PFCR_BAL_DISC_BIT   7
`define PFCR_BAL_FAST_BIT   6
`define PFCR_BAL_LPM_BIT    3
`define PFCR_BAL_RW_MASK    8'hC8

// Reset values
`define PFCR_TRIM_RST       8'h00
`define PFCR_COEF_RST       8'h00
`define PFCR_BAL_RST        8'h08
`define PFCR_PWR_RST        16'h0000
`define PFCR_RD_UNMAPPED    16'h0000

// Averaging over line cycles
`define PFCR_CYC_LAST       4'hF
`define PFCR_AVG_SHIFT      4

`endif

// File: hdl/pfcr_pkg.sv
// Types for the trim, filter and balance register bank.
// Assumes pfcr_consts.svh for all figures.
package pfcr_pkg;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_TRIM,
    SEL_COEF,
    SEL_PWR,
    SEL_BAL
  } pfcr_sel_t;

  typedef struct packed {
    logic [7:0]       trim;
    logic [3:0][7:0]  coef;
    logic [7:0]       bal_cfg;
    logic [19:0]      acc;
    logic [3:0]       cyc_cnt;
    logic [15:0]      avg;
    logic [15:0]      rd_data;
    logic             rd_valid;
    logic             trim_neg;
    logic [6:0]       trim_mag;
    logic [7:0]       filt_gain;
    logic [7:0]       filt_zero;
    logic             bal_active;
    logic [7:0]       bal_corr;
  } pfcr_state_t;

endpackage : pfcr_pkg

// File: hdl/pfcr_regs.sv
// Register bank: power meter gain trim, light-load filter coefficients,
// averaged power reading and current balance configuration.
// Assumes the register port, line status and datapath inputs share MCLK_IN.
`include "pfcr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module pfcr_regs
  import pfcr_pkg::*;
(
  // Clock and reset
  input  wire logic         MCLK_IN,
  input  wire logic         RESET_N_IN,
  // Register port
  input  wire logic [15:0]  ADDR_IN,
  input  wire logic         WR_EN_IN,
  input  wire logic [7:0]   WR_DATA_IN,
  input  wire logic         RD_EN_IN,
  output logic      [15:0]  RD_DATA_OUT,
  output logic              RD_VALID_OUT,
  // Line and load status
  input  wire logic         LL_FILTER_EN_IN,
  input  wire logic         HIGH_LINE_IN,
  input  wire logic         LIGHT_LOAD_IN,
  input  wire logic [7:0]   NORM_GAIN_IN,
  input  wire logic [7:0]   NORM_ZERO_IN,
  // Power meter
  input  wire logic [15:0]  LINE_POWER_IN,
  input  wire logic         LINE_CYCLE_DONE_IN,
  output logic              GAIN_TRIM_NEG_OUT,
  output logic      [6:0]   GAIN_TRIM_MAG_OUT,
  // Current loop filter coefficients
  output logic      [7:0]   FILT_GAIN_OUT,
  output logic      [7:0]   FILT_ZERO_OUT,
  // Current balance
  input  wire logic         FAST_LOOP_IN,
  input  wire logic         LOW_POWER_IN,
  input  wire logic         BAL_AT_LIMIT_IN,
  input  wire logic [7:0]   BAL_CORR_IN,
  output logic              BAL_ACTIVE_OUT,
  output logic      [7:0]   BAL_CORR_OUT
);

  pfcr_state_t st_reg;
  pfcr_state_t st_next;
  pfcr_sel_t   sel;
  logic [19:0] acc_sum;
  logic        bal_run;
  logic        ll_use;

  // Shared by the write path and the read mux
  function automatic pfcr_sel_t decode(input logic [15:0] addr);
    case (addr)
      `PFCR_ADDR_TRIM:    decode = SEL_TRIM;
      `PFCR_ADDR_LL_GAIN,
      `PFCR_ADDR_LL_ZERO,
      `PFCR_ADDR_HL_GAIN,
      `PFCR_ADDR_HL_ZERO: decode = SEL_COEF;
      `PFCR_ADDR_PWR:     decode = SEL_PWR;
      `PFCR_ADDR_BAL:     decode = SEL_BAL;
      default:            decode = SEL_NONE;
    endcase
  endfunction : decode

  assign sel     = decode(ADDR_IN);
  assign acc_sum = st_reg.acc + {4'h0, LINE_POWER_IN};
  assign ll_use  = LL_FILTER_EN_IN && LIGHT_LOAD_IN;

  // Balancing may be paused by a load transient or by the low power limit
  // R8 fast loop gate
  // R10 low power limit
  assign bal_run =
    !(FAST_LOOP_IN && !st_reg.bal_cfg[`PFCR_BAL_FAST_BIT]) &&
    !(LOW_POWER_IN && BAL_AT_LIMIT_IN &&
      st_reg.bal_cfg[`PFCR_BAL_LPM_BIT]);

  always_comb begin
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;

    // Writes; the power reading is not writable, so SEL_PWR is ignored
    if (WR_EN_IN) begin
      unique case (sel)
        SEL_TRIM: st_next.trim = WR_DATA_IN;
        // Coefficient addresses are contiguous, low bits are the index
        SEL_COEF: st_next.coef[ADDR_IN[1:0]] = WR_DATA_IN;
        // R12 reserved bits held
        SEL_BAL:  st_next.bal_cfg = WR_DATA_IN & `PFCR_BAL_RW_MASK;
        SEL_PWR,
        SEL_NONE: ;
      endcase
    end

    if (RD_EN_IN) begin
      st_next.rd_valid = 1'b1;
      unique case (sel)
        SEL_TRIM: st_next.rd_data = {8'h00, st_reg.trim};
        SEL_COEF: st_next.rd_data = {8'h00, st_reg.coef[ADDR_IN[1:0]]};
        SEL_PWR:  st_next.rd_data = st_reg.avg;
        SEL_BAL:  st_next.rd_data = {8'h00, st_reg.bal_cfg};
        SEL_NONE: st_next.rd_data = `PFCR_RD_UNMAPPED;
      endcase
    end

    // R6 sixteen cycle average
    if (LINE_CYCLE_DONE_IN) begin
      if (st_reg.cyc_cnt == `PFCR_CYC_LAST) begin
        st_next.avg     = 16'(acc_sum >> `PFCR_AVG_SHIFT);
        st_next.acc     = 20'h00000;
        st_next.cyc_cnt = 4'h0;
      end else begin
        st_next.acc     = acc_sum;
        st_next.cyc_cnt = st_reg.cyc_cnt + 4'h1;
      end
    end

    // R1 trim sign
    st_next.trim_neg = st_reg.trim[`PFCR_TRIM_SIGN_BIT];
    // R2 trim magnitude
    st_next.trim_mag = st_reg.trim[`PFCR_TRIM_MAG_MSB:0];

    // R5 light load enable
    if (ll_use && !HIGH_LINE_IN) begin
      // R3 low line coefficients
      st_next.filt_gain = st_reg.coef[0];
      st_next.filt_zero = st_reg.coef[1];
    end else if (ll_use) begin
      // R4 high line coefficients
      st_next.filt_gain = st_reg.coef[2];
      st_next.filt_zero = st_reg.coef[3];
    end else begin
      st_next.filt_gain = NORM_GAIN_IN;
      st_next.filt_zero = NORM_ZERO_IN;
    end

    st_next.bal_active = bal_run;
    // R7 disconnect from PWM
    if (st_reg.bal_cfg[`PFCR_BAL_DISC_BIT] || !bal_run) begin
      st_next.bal_corr = 8'h00;
    end else begin
      st_next.bal_corr = BAL_CORR_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_reg         <= '0;
      st_reg.trim    <= `PFCR_TRIM_RST;
      st_reg.coef    <= {4{`PFCR_COEF_RST}};
      // R11 limit stop on by default
      st_reg.bal_cfg <= `PFCR_BAL_RST;
      st_reg.avg     <= `PFCR_PWR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RD_DATA_OUT       = st_reg.rd_data;
  assign RD_VALID_OUT      = st_reg.rd_valid;
  assign GAIN_TRIM_NEG_OUT = st_reg.trim_neg;
  assign GAIN_TRIM_MAG_OUT = st_reg.trim_mag;
  assign FILT_GAIN_OUT     = st_reg.filt_gain;
  assign FILT_ZERO_OUT     = st_reg.filt_zero;
  assign BAL_ACTIVE_OUT    = st_reg.bal_active;
  assign BAL_CORR_OUT      = st_reg.bal_corr;

  // A write to the trim reaches the sign output two edges later
  AST_TRIM_SIGN: assert property ( // R1
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_EN_IN && ADDR_IN == `PFCR_ADDR_TRIM)
      |-> ##2 GAIN_TRIM_NEG_OUT == $past(WR_DATA_IN[7], 2))
    else $error("Gain trim sign does not follow the write");

  AST_TRIM_MAG: assert property ( // R2
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_EN_IN && ADDR_IN == `PFCR_ADDR_TRIM)
      |-> ##2 GAIN_TRIM_MAG_OUT == $past(WR_DATA_IN[6:0], 2))
    else $error("Gain trim magnitude does not follow the write");

  AST_LL_LOW_LINE: assert property ( // R3
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (LL_FILTER_EN_IN && LIGHT_LOAD_IN && !HIGH_LINE_IN)
      |=> (FILT_GAIN_OUT == $past(st_reg.coef[0]) &&
           FILT_ZERO_OUT == $past(st_reg.coef[1])))
    else $error("Low line light load coefficients not applied");

  AST_LL_HIGH_LINE: assert property ( // R4
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (LL_FILTER_EN_IN && LIGHT_LOAD_IN && HIGH_LINE_IN)
      |=> (FILT_GAIN_OUT == $past(st_reg.coef[2]) &&
           FILT_ZERO_OUT == $past(st_reg.coef[3])))
    else $error("High line light load coefficients not applied");

  AST_LL_DISABLED: assert property ( // R5
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !(LL_FILTER_EN_IN && LIGHT_LOAD_IN)
      |=> (FILT_GAIN_OUT == $past(NORM_GAIN_IN) &&
           FILT_ZERO_OUT == $past(NORM_ZERO_IN)))
    else $error("Normal coefficients not applied");

  AST_PWR_AVERAGE: assert property ( // R6
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (LINE_CYCLE_DONE_IN && st_reg.cyc_cnt == `PFCR_CYC_LAST)
      |=> st_reg.avg == $past(acc_sum[19:4]) && st_reg.acc == 20'h00000)
    else $error("Power average wrong after sixteen line cycles");

  AST_PWR_READ_ONLY: assert property ( // R6
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_EN_IN && ADDR_IN == `PFCR_ADDR_PWR && !LINE_CYCLE_DONE_IN)
      |=> $stable(st_reg.avg))
    else $error("Power reading changed by a write");

  AST_BAL_DISCONNECT: assert property ( // R7
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    st_reg.bal_cfg[7] |=> BAL_CORR_OUT == 8'h00)
    else $error("Balance correction reached PWM while disconnected");

  AST_BAL_FAST_LOOP: assert property ( // R8
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (FAST_LOOP_IN && !st_reg.bal_cfg[6]) |=> !BAL_ACTIVE_OUT)
    else $error("Balancing ran during fast loop");

  AST_BAL_LOW_POWER: assert property ( // R10
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (LOW_POWER_IN && BAL_AT_LIMIT_IN && st_reg.bal_cfg[3])
      |=> !BAL_ACTIVE_OUT && BAL_CORR_OUT == 8'h00)
    else $error("Balancing ran past its limit in low power");

  AST_BAL_RESERVED: assert property ( // R12
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (RD_EN_IN && ADDR_IN == `PFCR_ADDR_BAL)
      |=> RD_VALID_OUT && RD_DATA_OUT[5:4] == 2'h0 &&
          RD_DATA_OUT[2:0] == 3'h0)
    else $error("Reserved balance bits read as non-zero");

  // Connected and running: the datapath correction passes unchanged
  AST_BAL_CONNECT: assert property ( // R7
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (!st_reg.bal_cfg[`PFCR_BAL_DISC_BIT] && !FAST_LOOP_IN && !LOW_POWER_IN)
      |=> BAL_CORR_OUT == $past(BAL_CORR_IN))
    else $error("Balance correction not passed while connected");

  AST_BAL_FAST_KEEP: assert property ( // R8
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (FAST_LOOP_IN && st_reg.bal_cfg[`PFCR_BAL_FAST_BIT] && !LOW_POWER_IN)
      |=> BAL_ACTIVE_OUT)
    else $error("Balancing stopped during fast loop although kept on");

  AST_BAL_NO_LIMIT_STOP: assert property ( // R10
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (!st_reg.bal_cfg[`PFCR_BAL_LPM_BIT] && !FAST_LOOP_IN) |=> BAL_ACTIVE_OUT)
    else $error("Balancing stopped although the limit stop is off");

  // Spare balance bits never hold a one, whatever was written
  AST_BAL_SPARE_ZERO: assert property ( // R12
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (st_reg.bal_cfg & ~`PFCR_BAL_RW_MASK) == 8'h00)
    else $error("Spare balance bits hold a one");

  AST_BAL_WRITE: assert property ( // R12
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_EN_IN && ADDR_IN == `PFCR_ADDR_BAL)
      |=> st_reg.bal_cfg == ($past(WR_DATA_IN) & `PFCR_BAL_RW_MASK))
    else $error("Balance configuration write did not land");

  // A coefficient write lands at the edge that takes it
  AST_COEF_LOW_WRITE: assert property ( // R3
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_EN_IN && ADDR_IN == `PFCR_ADDR_LL_GAIN)
      |=> st_reg.coef[0] == $past(WR_DATA_IN))
    else $error("Low line gain write did not land");

  AST_COEF_HIGH_WRITE: assert property ( // R4
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_EN_IN && ADDR_IN == `PFCR_ADDR_HL_ZERO)
      |=> st_reg.coef[3] == $past(WR_DATA_IN))
    else $error("High line zero write did not land");

  AST_TRIM_READ: assert property ( // R2
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (RD_EN_IN && ADDR_IN == `PFCR_ADDR_TRIM)
      |=> RD_DATA_OUT == {8'h00, $past(st_reg.trim)})
    else $error("Gain trim read returned the wrong value");

  AST_PWR_READ: assert property ( // R6
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (RD_EN_IN && ADDR_IN == `PFCR_ADDR_PWR)
      |=> RD_DATA_OUT == $past(st_reg.avg))
    else $error("Power reading read returned the wrong value");

  // Without a line cycle nothing in the averager moves
  AST_PWR_HOLD: assert property ( // R6
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !LINE_CYCLE_DONE_IN |=> $stable(st_reg.avg) && $stable(st_reg.cyc_cnt))
    else $error("Averager moved without a line cycle");

  AST_PWR_COUNT: assert property ( // R6
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (LINE_CYCLE_DONE_IN && st_reg.cyc_cnt != `PFCR_CYC_LAST)
      |=> st_reg.cyc_cnt == $past(st_reg.cyc_cnt) + 4'h1 &&
          $stable(st_reg.avg))
    else $error("Line cycle count or early reading wrong");

endmodule : pfcr_regs

`default_nettype wire

// File: sim/pfcr_regs_tb.sv
// Self-checking bench for the trim, filter and balance register bank.
// Assumes the byte strobe register port and same-clock status inputs.
`timescale 1ns/1ns
`default_nettype none
`include "pfcr_consts.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  fail_count++; $display("wrong value %s expected %0h seen %0h", nm, ex, gt); \
  end end

module pfcr_regs_tb;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        wr_en = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic        rd_en = 1'b0;
  logic        ll_en = 1'b0, high_line = 1'b0, light_load = 1'b0;
  logic [7:0]  norm_gain = 8'h00, norm_zero = 8'h00;
  logic [15:0] line_power = 16'h0000;
  logic        cycle_done = 1'b0;
  logic        fast = 1'b0, low_pwr = 1'b0, at_limit = 1'b0;
  logic [7:0]  bal_corr = 8'h00;
  logic [15:0] rd_data;
  logic        rd_valid, trim_neg, bal_active;
  logic [6:0]  trim_mag;
  logic [7:0]  filt_gain, filt_zero, bal_corr_out, v;
  logic [7:0]  coef [4];
  logic [19:0] sum;
  logic [15:0] e16;
  int          fail_count = 0;
  int          total_checks = 0;

  pfcr_regs pfcr_regs_inst (.MCLK_IN(mclk), .RESET_N_IN(rst_n),
    .ADDR_IN(addr), .WR_EN_IN(wr_en), .WR_DATA_IN(wr_data),
    .RD_EN_IN(rd_en), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
    .LL_FILTER_EN_IN(ll_en), .HIGH_LINE_IN(high_line),
    .LIGHT_LOAD_IN(light_load), .NORM_GAIN_IN(norm_gain),
    .NORM_ZERO_IN(norm_zero), .LINE_POWER_IN(line_power),
    .LINE_CYCLE_DONE_IN(cycle_done), .GAIN_TRIM_NEG_OUT(trim_neg),
    .GAIN_TRIM_MAG_OUT(trim_mag), .FILT_GAIN_OUT(filt_gain),
    .FILT_ZERO_OUT(filt_zero), .FAST_LOOP_IN(fast),
    .LOW_POWER_IN(low_pwr), .BAL_AT_LIMIT_IN(at_limit),
    .BAL_CORR_IN(bal_corr), .BAL_ACTIVE_OUT(bal_active),
    .BAL_CORR_OUT(bal_corr_out));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] ex,
                    input string nm);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    `CHK(nm, 1'b1, rd_valid)
    `CHK(nm, ex, rd_data)
  endtask : rd

  // Sum of line cycle samples, kept beside the design's own accumulator
  task automatic pulses(input int n);
    logic [15:0] p;
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      p = 16'($urandom);
      line_power <= p;
      cycle_done <= 1'b1;
      sum = sum + 20'(p);
    end
    @(posedge mclk);
    cycle_done <= 1'b0;
  endtask : pulses

  function automatic logic [8:0] bal_exp(input logic [7:0] c,
    input logic f, input logic lp, input logic lim, input logic [7:0] x);
    logic act;
    act = !(f && !c[6]) && !(lp && lim && c[3]);
    return {act, (act && !c[7]) ? x : 8'h00};
  endfunction : bal_exp

  task automatic print_verdict;
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(43052));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`PFCR_ADDR_TRIM, 16'h0000, "trim reset");
    rd(`PFCR_ADDR_BAL, 16'h0008, "balance reset");
    rd(`PFCR_ADDR_PWR, 16'h0000, "power reset");
    rd(16'hFE4F, 16'h0000, "unmapped read");
    // sign and magnitude, both extremes first
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      wr(`PFCR_ADDR_TRIM, v);
      @(posedge mclk);
      #1;
      `CHK("trim sign", v[7], trim_neg)
      `CHK("trim magnitude", v[6:0], trim_mag)
      rd(`PFCR_ADDR_TRIM, {8'h00, v}, "trim readback");
    end
    for (int i = 0; i < 4; i++) begin
      coef[i] = 8'($urandom);
      wr(`PFCR_ADDR_LL_GAIN + 16'(i), coef[i]);
    end
    for (int i = 0; i < 4; i++)
      rd(`PFCR_ADDR_LL_GAIN + 16'(i), {8'h00, coef[i]}, "coef");
    // every enable, line and load combination
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      {ll_en, high_line, light_load} <= 3'(i);
      norm_gain <= 8'($urandom);
      norm_zero <= 8'($urandom);
      @(posedge mclk);
      #1;
      v = (ll_en && light_load) ? coef[high_line ? 2 : 0] : norm_gain;
      `CHK("gain", v, filt_gain)
      v = (ll_en && light_load) ? coef[high_line ? 3 : 1] : norm_zero;
      `CHK("zero", v, filt_zero)
    end
    wr(`PFCR_ADDR_BAL, 8'hFF);
    rd(`PFCR_ADDR_BAL, 16'h00C8, "reserved bits");
    wr(`PFCR_ADDR_PWR, 8'h55);
    rd(`PFCR_ADDR_PWR, 16'h0000, "read-only power");
    for (int i = 0; i < 40; i++) begin
      v = (i == 0) ? 8'h08 : 8'($urandom); // advised setting first
      wr(`PFCR_ADDR_BAL, v);
      @(posedge mclk);
      {fast, low_pwr, at_limit} <= 3'($urandom);
      bal_corr <= 8'($urandom);
      @(posedge mclk);
      #1;
      e16 = {7'h00, bal_exp(v, fast, low_pwr, at_limit, bal_corr)};
      `CHK("balance active", e16[8], bal_active)
      `CHK("balance correction", e16[7:0], bal_corr_out)
    end
    // fifteen cycles leave the reading alone, the sixteenth updates it
    sum = 20'h00000;
    pulses(16);
    rd(`PFCR_ADDR_PWR, sum[19:4], "average");
    v = 8'h00;
    e16 = sum[19:4];
    sum = 20'h00000;
    pulses(15);
    rd(`PFCR_ADDR_PWR, e16, "partial average");
    pulses(1);
    rd(`PFCR_ADDR_PWR, sum[19:4], "second average");
    print_verdict();
  end
endmodule : pfcr_regs_tb
`default_nettype wire
